/* File: rxsps_defines.vh */
// constants of the receiver self-polling scheduler
// assumes inclusion by bare name from the scheduler module and the test bench
//
// What this block does
// [R01] permanent search in constant mode restarts the channel sequence, never sleeps early
// [R02] after last channel, permanent search restarts at config A channel 1 until on time
// [R03] each master period end starts a new polling cycle unless masked
// [R04] masking gives M active then N idle master periods in any polling mode
// [R05] masking applies only when control bit 2 is set
// [R06] mode field 1:0: 00 constant, 01 fast fall back, 10 mixed
// [R07] control bit 3 enables permanent wake-up search
// [R08] reference tick every 64 clocks times prescale count, zero means 256
// [R09] off time is count times reference period, zero means 16384
// [R10] off count: low register bits 7:0, high register bits 5:0 give 13:8
// [R11] active period field bits 4:0, 1 to 31, zero means 256
// [R12] idle period field 8 bits, zero means 256
// [R13] fast fall back keeps the config A on timer running after early sleep
// [R14] master period is on time followed by off time
// [R15] after idle periods, active count restarts and pattern repeats
`ifndef RXSPS_DEFINES_VH
`define RXSPS_DEFINES_VH

`define RXSPS_IDX_MODE_CTRL   8'h00
`define RXSPS_IDX_PRESCALE    8'h08
`define RXSPS_IDX_OFF_LOW     8'h09
`define RXSPS_IDX_OFF_HIGH    8'h0A
`define RXSPS_IDX_ACTIVE_CNT  8'h0B
`define RXSPS_IDX_IDLE_CNT    8'h0C
`define RXSPS_IDX_STATUS      8'h10

`define RXSPS_RST_MODE_CTRL   8'h00
`define RXSPS_RST_PRESCALE    8'h01
`define RXSPS_RST_OFF_LOW     8'h01
`define RXSPS_RST_OFF_HIGH    8'h00
`define RXSPS_RST_ACTIVE_CNT  8'h01
`define RXSPS_RST_IDLE_CNT    8'h01

`define RXSPS_BIT_CONT_SEARCH 3
`define RXSPS_BIT_MASK_EN     2
`define RXSPS_MODE_MSB        1
`define RXSPS_MODE_LSB        0
`define RXSPS_MODE_CONST      2'h0
`define RXSPS_MODE_FFB        2'h1
`define RXSPS_MODE_MIXED      2'h2
`define RXSPS_ACTIVE_MSB      4
`define RXSPS_OFF_HIGH_MSB    5

`define RXSPS_PRE_TICK_LAST   6'h3F
`define RXSPS_COUNT_MAX       9'h100
`define RXSPS_OFF_MAX         15'h4000
`define RXSPS_RESP_OKAY       2'h0
`define RXSPS_RESP_SLVERR     2'h2

`endif

/* File: rxsps_scheduler.v */
// receiver self-polling scheduler: reference timer, off timer, period masking
// assumes a config A on timer and channel sequencer outside, all on mclk
`include "rxsps_defines.vh"

module rxsps_scheduler
(
  input  wire        mclk,
  input  wire        reset,
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire        on_time_done,
  input  wire        last_channel_done,
  input  wire        config_b_active,
  output reg         rx_active_ff,
  output reg         on_timer_start_ff,
  output reg         search_restart_ff,
  output reg         reference_tick_ff,
  output reg         period_active_ff
);

  localparam ST_ON  = 1'b0;
  localparam ST_OFF = 1'b1;

  // register storage
  reg  [7:0]  mode_ctrl_ff;
  reg  [7:0]  prescale_ff;
  reg  [7:0]  off_low_ff;
  reg  [7:0]  off_high_ff;
  reg  [7:0]  active_cnt_ff;
  reg  [7:0]  idle_cnt_ff;

  // bus handshake state
  reg         aw_got_ff;
  reg         w_got_ff;
  reg  [7:0]  aw_addr_ff;
  reg  [31:0] w_data_ff;
  reg  [3:0]  w_strb_ff;

  // timing state
  reg  [5:0]  pre_cnt_ff;
  reg  [8:0]  ref_cnt_ff;
  reg  [14:0] off_cnt_ff;
  reg         state_ff;
  reg  [8:0]  seg_cnt_ff;
  reg         seg_idle_ff;
  reg         mask_en_q_ff;
  reg         first_ff;

  reg  [5:0]  nxt_pre_cnt;
  reg  [8:0]  nxt_ref_cnt;
  reg         nxt_ref_tick;
  reg  [14:0] nxt_off_cnt;
  reg         nxt_state;
  reg  [8:0]  nxt_seg_cnt;
  reg         nxt_seg_idle;
  reg         nxt_period_active;
  reg         nxt_rx_active;
  reg         nxt_on_start;
  reg         nxt_restart;
  reg         period_start;

  wire [1:0]  mode_sel;
  wire        mask_en;
  wire        cont_search;
  wire        do_write;
  wire [7:0]  wr_idx;
  wire [7:0]  rd_idx;
  wire [13:0] off_count;

  // count field of up to 8 bits where zero means 256
  function [8:0] count_of;
    input [7:0] val;
    begin
      if (val == 8'h00)
        count_of = `RXSPS_COUNT_MAX;
      else
        count_of = {1'b0, val};
    end
  endfunction

  // mapped register index check
  function is_mapped;
    input [7:0] idx;
    begin
      case (idx)
        `RXSPS_IDX_MODE_CTRL,
        `RXSPS_IDX_PRESCALE,
        `RXSPS_IDX_OFF_LOW,
        `RXSPS_IDX_OFF_HIGH,
        `RXSPS_IDX_ACTIVE_CNT,
        `RXSPS_IDX_IDLE_CNT,
        `RXSPS_IDX_STATUS:
          is_mapped = 1'b1;
        default:
          is_mapped = 1'b0;
      endcase
    end
  endfunction

  assign mode_sel    = mode_ctrl_ff[`RXSPS_MODE_MSB:`RXSPS_MODE_LSB]; // [R06]
  assign mask_en     = mode_ctrl_ff[`RXSPS_BIT_MASK_EN];              // [R05]
  assign cont_search = mode_ctrl_ff[`RXSPS_BIT_CONT_SEARCH];          // [R07]
  assign off_count   = {off_high_ff[`RXSPS_OFF_HIGH_MSB:0], off_low_ff}; // [R10]
  assign do_write    = aw_got_ff && w_got_ff && !s_axi_bvalid;
  assign wr_idx      = {2'h0, aw_addr_ff[7:2]};
  assign rd_idx      = {2'h0, s_axi_araddr[7:2]};

  // write address and data channels, taken in either order
  always @(posedge mclk)
  begin
    if (reset)
    begin
      aw_got_ff     <= 1'b0;
      w_got_ff      <= 1'b0;
      aw_addr_ff    <= 8'h00;
      w_data_ff     <= 32'h00000000;
      w_strb_ff     <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `RXSPS_RESP_OKAY;
    end
    else
    begin
      s_axi_awready <= !aw_got_ff && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
      s_axi_wready  <= !w_got_ff && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_got_ff  <= 1'b1;
        aw_addr_ff <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_got_ff  <= 1'b1;
        w_data_ff <= s_axi_wdata;
        w_strb_ff <= s_axi_wstrb;
      end
      if (do_write)
      begin
        s_axi_bvalid <= 1'b1;
        aw_got_ff    <= 1'b0;
        w_got_ff     <= 1'b0;
        if (is_mapped(wr_idx))
          s_axi_bresp <= `RXSPS_RESP_OKAY;
        else
          s_axi_bresp <= `RXSPS_RESP_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // register writes, low byte lane only
  always @(posedge mclk)
  begin
    if (reset)
    begin
      mode_ctrl_ff  <= `RXSPS_RST_MODE_CTRL;
      prescale_ff   <= `RXSPS_RST_PRESCALE;
      off_low_ff    <= `RXSPS_RST_OFF_LOW;
      off_high_ff   <= `RXSPS_RST_OFF_HIGH;
      active_cnt_ff <= `RXSPS_RST_ACTIVE_CNT;
      idle_cnt_ff   <= `RXSPS_RST_IDLE_CNT;
    end
    else if (do_write && w_strb_ff[0])
    begin
      case (wr_idx)
        `RXSPS_IDX_MODE_CTRL:  mode_ctrl_ff  <= {4'h0, w_data_ff[3:0]};
        `RXSPS_IDX_PRESCALE:   prescale_ff   <= w_data_ff[7:0];
        `RXSPS_IDX_OFF_LOW:    off_low_ff    <= w_data_ff[7:0];
        `RXSPS_IDX_OFF_HIGH:   off_high_ff   <= {2'h0, w_data_ff[5:0]};
        `RXSPS_IDX_ACTIVE_CNT: active_cnt_ff <= {3'h0, w_data_ff[4:0]};
        `RXSPS_IDX_IDLE_CNT:   idle_cnt_ff   <= w_data_ff[7:0];
        default:               mode_ctrl_ff  <= mode_ctrl_ff;
      endcase
    end
  end

  // read channel: setup registers are write-only, status shows the scheduler
  always @(posedge mclk)
  begin
    if (reset)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `RXSPS_RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        if (rd_idx == `RXSPS_IDX_STATUS)
          s_axi_rdata <= {24'h000000, seg_cnt_ff[8:0] == 9'h000, 3'h0,
                          seg_idle_ff, state_ff, period_active_ff, rx_active_ff};
        else
          s_axi_rdata <= 32'h00000000;
        if (is_mapped(rd_idx))
          s_axi_rresp <= `RXSPS_RESP_OKAY;
        else
          s_axi_rresp <= `RXSPS_RESP_SLVERR;
      end
      else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  // reference timer: 64-clock prescaler then programmed count
  always @*
  begin
    nxt_ref_tick = 1'b0;
    nxt_ref_cnt  = ref_cnt_ff;
    if (pre_cnt_ff == `RXSPS_PRE_TICK_LAST)
      nxt_pre_cnt = 6'h00;
    else
      nxt_pre_cnt = pre_cnt_ff + 6'h01;
    if (pre_cnt_ff == `RXSPS_PRE_TICK_LAST)
    begin
      if (ref_cnt_ff + 9'h001 >= count_of(prescale_ff)) // [R08]
      begin
        nxt_ref_cnt  = 9'h000;
        nxt_ref_tick = 1'b1;
      end
      else
        nxt_ref_cnt = ref_cnt_ff + 9'h001;
    end
  end

  // master period sequencing and masking
  always @*
  begin
    nxt_state         = state_ff;
    nxt_off_cnt       = off_cnt_ff;
    nxt_seg_cnt       = seg_cnt_ff;
    nxt_seg_idle      = seg_idle_ff;
    nxt_period_active = period_active_ff;
    nxt_rx_active     = rx_active_ff;
    nxt_on_start      = 1'b0;
    nxt_restart       = 1'b0;
    period_start      = first_ff;
    case (state_ff)
      ST_ON:
      begin
        if (on_time_done)
        begin
          nxt_state     = ST_OFF; // [R14]
          nxt_rx_active = 1'b0;
          nxt_off_cnt   = (off_count == 14'h0000) ? `RXSPS_OFF_MAX : {1'b0, off_count}; // [R09]
        end
        else if (last_channel_done && rx_active_ff)
        begin
          if (mode_sel == `RXSPS_MODE_CONST && cont_search)
            nxt_restart = 1'b1; // [R01] [R02]
          else if (mode_sel == `RXSPS_MODE_FFB ||
                   (mode_sel == `RXSPS_MODE_MIXED && config_b_active))
            nxt_rx_active = 1'b0; // [R13]
        end
      end
      ST_OFF:
      begin
        if (reference_tick_ff)
        begin
          if (off_cnt_ff == 15'h0001)
            period_start = 1'b1; // [R03]
          else
            nxt_off_cnt = off_cnt_ff - 15'h0001;
        end
      end
      default:
        nxt_state = ST_ON;
    endcase
    if (period_start)
    begin
      nxt_state    = ST_ON;
      nxt_on_start = 1'b1; // [R13]
      if (!mask_en || !mask_en_q_ff)
      begin
        nxt_seg_idle      = 1'b0;
        nxt_period_active = 1'b1;
        nxt_seg_cnt       = count_of({3'h0, active_cnt_ff[`RXSPS_ACTIVE_MSB:0]}) - 9'h001; // [R11]
      end
      else if (seg_cnt_ff == 9'h000)
      begin
        nxt_seg_idle      = !seg_idle_ff; // [R04] [R15]
        nxt_period_active = seg_idle_ff;
        if (seg_idle_ff)
          nxt_seg_cnt = count_of({3'h0, active_cnt_ff[`RXSPS_ACTIVE_MSB:0]}) - 9'h001;
        else
          nxt_seg_cnt = count_of(idle_cnt_ff) - 9'h001; // [R12]
      end
      else
      begin
        nxt_seg_cnt       = seg_cnt_ff - 9'h001;
        nxt_period_active = !seg_idle_ff;
      end
      nxt_rx_active = nxt_period_active;
    end
  end

  always @(posedge mclk)
  begin
    if (reset)
    begin
      pre_cnt_ff        <= 6'h00;
      ref_cnt_ff        <= 9'h000;
      reference_tick_ff <= 1'b0;
      off_cnt_ff        <= 15'h0000;
      state_ff          <= ST_OFF;
      seg_cnt_ff        <= 9'h000;
      seg_idle_ff       <= 1'b0;
      mask_en_q_ff      <= 1'b0;
      first_ff          <= 1'b1;
      period_active_ff  <= 1'b0;
      rx_active_ff      <= 1'b0;
      on_timer_start_ff <= 1'b0;
      search_restart_ff <= 1'b0;
    end
    else
    begin
      pre_cnt_ff        <= nxt_pre_cnt;
      ref_cnt_ff        <= nxt_ref_cnt;
      reference_tick_ff <= nxt_ref_tick;
      off_cnt_ff        <= nxt_off_cnt;
      state_ff          <= nxt_state;
      seg_cnt_ff        <= nxt_seg_cnt;
      seg_idle_ff       <= nxt_seg_idle;
      first_ff          <= 1'b0;
      period_active_ff  <= nxt_period_active;
      rx_active_ff      <= nxt_rx_active;
      on_timer_start_ff <= nxt_on_start;
      search_restart_ff <= nxt_restart;
      if (period_start)
        mask_en_q_ff <= mask_en; // [R05]
    end
  end

endmodule

/* File: rxsps_monitor.sv */
// port checker of the self-polling scheduler
// assumes binding into rxsps_scheduler, single clock mclk
module rxsps_monitor
(
  input wire       mclk,
  input wire       reset,
  input wire       s_axi_arvalid,
  input wire       s_axi_arready,
  input wire       s_axi_rvalid,
  input wire       on_time_done,
  input wire       last_channel_done,
  input wire       rx_active_ff,
  input wire       on_timer_start_ff,
  input wire       search_restart_ff,
  input wire       reference_tick_ff,
  input wire       period_active_ff
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] gap_ff;
  logic        seen_ff;
  // cycles since the last reference tick
  always @(posedge mclk)
  begin
    if (reset)
    begin
      gap_ff  <= 16'h0000;
      seen_ff <= 1'b0;
    end
    else
    begin
      gap_ff  <= reference_tick_ff ? 16'h0001 : gap_ff + 16'h0001;
      seen_ff <= seen_ff | reference_tick_ff;
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  tick_gap_a: assert property (
    reference_tick_ff && seen_ff |-> gap_ff[5:0] == 6'h00) else $error("tick gap");
  off_entry_a: assert property (
    rx_active_ff && on_time_done && !on_timer_start_ff |=> !rx_active_ff) else $error("off");
  restart_cause_a: assert property (
    search_restart_ff |-> $past(last_channel_done) || $past(last_channel_done, 2))
    else $error("restart cause");
  restart_awake_a: assert property (
    search_restart_ff |-> rx_active_ff) else $error("restart asleep");
  rise_start_a: assert property (
    $rose(rx_active_ff) |-> on_timer_start_ff) else $error("wake off start");
  idle_quiet_a: assert property (
    !period_active_ff |-> !rx_active_ff) else $error("awake in idle");
  mask_edge_a: assert property (
    $changed(period_active_ff) |-> on_timer_start_ff) else $error("mask mid period");
  start_pulse_a: assert property (
    on_timer_start_ff |=> !on_timer_start_ff) else $error("start pulse long");
  read_answer_a: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read answer late");
  cover property (search_restart_ff);
  cover property ($fell(period_active_ff));
  cover property (rx_active_ff && last_channel_done ##2 !rx_active_ff);
endmodule

/* File: test_receiver_self_polling_scheduler.sv */
// self-checking bench of the self-polling scheduler
// assumes rxsps_scheduler, its defines header and rxsps_monitor
`include "rxsps_defines.vh"
module test_receiver_self_polling_scheduler;
  timeunit 1ns;
  timeprecision 1ns;
  logic        mclk = 0, reset = 1, on_time_done = 0, last_channel_done = 0;
  logic        config_b_active = 0, s_axi_bready = 0, s_axi_rready = 0;
  logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_arvalid = 0;
  logic [7:0]  s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, rng = 32'hB8E5AE01;
  logic [3:0]  s_axi_wstrb = 4'hF;
  wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire         rx_active_ff, on_timer_start_ff, search_restart_ff;
  wire         reference_tick_ff, period_active_ff;
  wire [1:0]   s_axi_bresp, s_axi_rresp;
  wire [31:0]  s_axi_rdata;
  int          fail_count = 0, compares = 0, cycles = 0;
  logic [1:0]  b_q[$];
  logic [33:0] r_q[$];
  logic [6:0]  s;
  logic        x, seen;
  logic [10:0] tbl [5] = '{11'h043, 11'h008, 11'h014, 11'h012, 11'h002};
  rxsps_scheduler rxsps_scheduler_inst (.*);
  initial forever #25 mclk = ~mclk;
  function automatic logic [31:0] xs();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng;
  endfunction
  task automatic tally_and_finish();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input string what, input logic [33:0] e, input logic [33:0] g);
    compares++;
    if (g !== e)
    begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v,
                    input logic [1:0] e = `RXSPS_RESP_OKAY);
    logic [31:0] r;
    @(posedge mclk);
    r = xs();
    b_q.push_back(e);
    s_axi_awaddr <= {a[5:0], 2'b00};
    s_axi_wdata <= {r[31:8], v};
    s_axi_wstrb <= {r[2:0], 1'b1};
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    do
    begin
      @(posedge mclk);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [33:0] e);
    @(posedge mclk);
    r_q.push_back(e);
    s_axi_araddr <= {a[5:0], 2'b00};
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do
    begin
      @(posedge mclk);
      if (s_axi_arready) s_axi_arvalid <= 0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 0;
  endtask
  // ends the on time and times the off time up to the next period start
  task automatic offt(input int lo, input int hi);
    int n;
    on_time_done <= 1;
    @(posedge mclk);
    on_time_done <= 0;
    n = 0;
    do
    begin
      @(posedge mclk);
      n++;
    end while (on_timer_start_ff !== 1'b1);
    chk("off time in window", 1, n >= lo && n <= hi);
  endtask
  task automatic per(output logic pa);
    pa = period_active_ff;
    offt(0, 68);
  endtask
  task automatic gap(input int e);
    int n;
    repeat (2) do @(posedge mclk); while (reference_tick_ff !== 1'b1);
    n = 0;
    do
    begin
      @(posedge mclk);
      n++;
    end while (reference_tick_ff !== 1'b1);
    chk("tick gap", e, n);
  endtask
  // bus answers against the oldest note
  always @(posedge mclk)
  begin
    cycles++;
    if (s_axi_bvalid === 1'b1 && s_axi_bready) chk("bresp", b_q.pop_front(), s_axi_bresp);
    if (s_axi_rvalid === 1'b1 && s_axi_rready)
      chk("read", r_q.pop_front(), {s_axi_rresp, s_axi_rdata});
    if (cycles == 90000)
    begin
      fail_count++;
      $display("CHECK FAILED timeout expected end seen hang");
      tally_and_finish();
    end
  end
  initial
  begin
    repeat (12) @(posedge mclk);
    reset <= 0;
    gap(64);
    offt(0, 68);
    rd(`RXSPS_IDX_MODE_CTRL, 34'h0);
    rd(8'h3F, {`RXSPS_RESP_SLVERR, 32'h0});
    wr(8'h3F, 8'h55, `RXSPS_RESP_SLVERR);
    $display("registers done");
    wr(`RXSPS_IDX_PRESCALE, 8'h03);
    gap(192);
    wr(`RXSPS_IDX_PRESCALE, 8'h00);
    gap(16384);
    wr(`RXSPS_IDX_PRESCALE, 8'h02);
    wr(`RXSPS_IDX_OFF_LOW, 8'h03);
    offt(256, 388);
    wr(`RXSPS_IDX_PRESCALE, 8'h01);
    wr(`RXSPS_IDX_OFF_LOW, 8'h00);
    wr(`RXSPS_IDX_OFF_HIGH, 8'hC1);
    offt(16320, 16388);
    wr(`RXSPS_IDX_OFF_HIGH, 8'h00);
    wr(`RXSPS_IDX_OFF_LOW, 8'h01);
    $display("timing done");
    wr(`RXSPS_IDX_ACTIVE_CNT, 8'hE2);
    wr(`RXSPS_IDX_IDLE_CNT, 8'h01);
    wr(`RXSPS_IDX_MODE_CTRL, 8'h04);
    for (int i = 0; i < 7; i++) per(s[i]);
    for (int i = 1; i < 4; i++) chk("mask repeat", s[i], s[i+3]);
    chk("active periods", 2, $countones(s[3:1]));
    wr(`RXSPS_IDX_MODE_CTRL, 8'h00);
    per(x);
    per(x);
    per(x);
    chk("mask off", 1, x);
    rd(`RXSPS_IDX_STATUS, 34'h3);
    $display("masking done");
    foreach (tbl[i])
    begin
      wr(`RXSPS_IDX_MODE_CTRL, tbl[i][10:3]);
      config_b_active <= tbl[i][2];
      last_channel_done <= 1;
      @(posedge mclk);
      last_channel_done <= 0;
      seen = 0;
      repeat (3) @(posedge mclk) seen = seen | search_restart_ff;
      chk("restart", tbl[i][0], seen);
      chk("awake", tbl[i][1], rx_active_ff);
      offt(0, 68);
    end
    $display("modes done");
    tally_and_finish();
  end
endmodule
bind rxsps_scheduler rxsps_monitor rxsps_monitor_inst (.*);
